/* File: common/aar_pkg.sv */
/*
  Constants for the auto-negotiation advertisement register: address, field
  positions, reset value, write mask and the fixed selector code.
  Assumes a 5-bit management address and 16-bit register data.
*/
package aar_pkg;
  localparam int          ADDR_W          = 5;
  localparam int          DATA_W          = 16;
  localparam logic [4:0]  ADV_ADDR        = 5'h04;
  localparam logic [15:0] ADV_RESET       = 16'h01e1;
  // only remote fault and the technology field take software writes
  localparam logic [15:0] ADV_WR_MASK     = 16'h21e0;
  localparam logic [15:0] ADV_RSVD_MASK   = 16'h5e00;
  localparam int          NEXT_PAGE_BIT   = 15;
  localparam int          REMOTE_FAULT_BIT = 13;
  localparam int          TECH_HI         = 8;
  localparam int          TECH_LO         = 5;
  localparam int          FDX_100TX_BIT   = 8;
  localparam int          SEL_HI          = 4;
  localparam logic [4:0]  SEL_IEEE8023    = 5'h01;
  localparam logic        NEXT_PAGE_VAL   = 1'b0;
  localparam logic [15:0] RDATA_RESET     = 16'h0000;
  localparam int          LOAD_DELAY      = 2;
endpackage

/* File: common/aar_if.sv */
/*
  Carrier between the control logic and the staged and active advertisement
  copies. Assumes all three ends share sys_clk.
*/
`timescale 1ns/1ps
interface aar_if;
  logic        wr;
  logic [15:0] wdata;
  logic        load;
  logic [15:0] staged;
  logic [15:0] active;

  modport ctrl_mp  (output wr, output wdata, output load, input staged, input active);
  modport stage_mp (input wr, input wdata, output staged);
  modport snap_mp  (input load, input staged, output active);
endinterface

/* File: hdl/aar_stage.sv */
/*
  Software-visible staged copy of the advertisement word.
  Assumes wr is a one-cycle pulse already qualified by address.
*/
`timescale 1ns/1ps
module aar_stage (
  input wire logic   sys_clk,
  input wire logic   rst,
  aar_if.stage_mp    bus
);
  logic [15:0] next_staged;

  // read-only bits always come from the constant, never from wdata
  always_comb begin
    next_staged = (bus.wdata & aar_pkg::ADV_WR_MASK) | (aar_pkg::ADV_RESET & ~aar_pkg::ADV_WR_MASK);
    next_staged[aar_pkg::NEXT_PAGE_BIT] = aar_pkg::NEXT_PAGE_VAL;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus.staged <= aar_pkg::ADV_RESET;
    end else if (bus.wr) begin
      bus.staged <= next_staged;
    end
  end
endmodule // aar_stage

/* File: hdl/aar_snap.sv */
/*
  Active advertisement word as seen by the negotiation engine.
  Assumes load is a one-cycle pulse derived from a negotiation restart.
*/
`timescale 1ns/1ps
module aar_snap (
  input wire logic   sys_clk,
  input wire logic   rst,
  aar_if.snap_mp     bus
);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus.active <= aar_pkg::ADV_RESET;
    end else if (bus.load) begin
      bus.active <= bus.staged;
    end
  end
endmodule // aar_snap

/* File: hdl/aar_top.sv */
/*
  Auto-negotiation advertisement register: management port slave, staged
  copy for software, active copy handed to the negotiation engine.
  Assumes restart_negotiation comes from control register logic on sys_clk,
  and that the engine samples adv_word when adv_update pulses.
*/
`timescale 1ns/1ps
module aar_top (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        restart_negotiation,
  output logic      [15:0] adv_word,
  output logic             adv_remote_fault,
  output logic      [3:0]  adv_tech_ability,
  output logic             adv_fdx_100tx,
  output logic             adv_update,
  output logic             adv_pending
);
  aar_if link ();

  logic hit;
  logic restart_q;
  logic restart_rise;
  logic load_q;

  assign hit          = (reg_addr == aar_pkg::ADV_ADDR);
  assign restart_rise = restart_negotiation & ~restart_q;

  assign link.wr    = reg_wr & hit;
  assign link.wdata = reg_wdata;
  assign link.load  = load_q;

  aar_stage u_stage (
    .sys_clk (sys_clk),
    .rst     (rst),
    .bus     (link)
  );

  aar_snap u_snap (
    .sys_clk (sys_clk),
    .rst     (rst),
    .bus     (link)
  );

  // restart edge, delayed a cycle so a write beside the restart is included
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      restart_q <= 1'b0;
      load_q    <= 1'b0;
    end else begin
      restart_q <= restart_negotiation;
      load_q    <= restart_rise;
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= aar_pkg::RDATA_RESET;
    end else if (reg_rd && hit) begin
      reg_rdata <= link.staged;
    end else begin
      reg_rdata <= aar_pkg::RDATA_RESET;
    end
  end

  // engine-facing fields mirror the active copy only
  assign adv_word = link.active;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      adv_remote_fault <= aar_pkg::ADV_RESET[aar_pkg::REMOTE_FAULT_BIT];
      adv_tech_ability <= aar_pkg::ADV_RESET[aar_pkg::TECH_HI:aar_pkg::TECH_LO];
      adv_fdx_100tx    <= aar_pkg::ADV_RESET[aar_pkg::FDX_100TX_BIT];
      adv_update       <= 1'b0;
    end else if (load_q) begin
      adv_remote_fault <= link.staged[aar_pkg::REMOTE_FAULT_BIT];
      adv_tech_ability <= link.staged[aar_pkg::TECH_HI:aar_pkg::TECH_LO];
      adv_fdx_100tx    <= link.staged[aar_pkg::FDX_100TX_BIT];
      adv_update       <= 1'b1;
    end else begin
      adv_update       <= 1'b0;
    end
  end

  // tells software a restart is still needed to apply its edits
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      adv_pending <= 1'b0;
    end else begin
      adv_pending <= (link.staged != link.active) & ~load_q;
    end
  end

  reset_value_a: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> (link.staged == aar_pkg::ADV_RESET && adv_word == aar_pkg::ADV_RESET))
    else $error("advertisement not at reset value after reset");

  next_page_a: assert property (@(posedge sys_clk) disable iff (rst)
    link.staged[15] == 1'b0 && reg_rdata[15] == 1'b0)
    else $error("next page bit not zero");

  reserved_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && hit |=> (reg_rdata & aar_pkg::ADV_RSVD_MASK) == 16'h0000 && link.staged[14] == 1'b0
      && link.staged[12:9] == 4'h0)
    else $error("reserved bits not zero");

  selector_fixed_a: assert property (@(posedge sys_clk) disable iff (rst)
    adv_word[4:0] == 5'h01 && link.staged[4:0] == 5'h01)
    else $error("selector field not 0x01");

  tech_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && hit |=> link.staged[8:5] == $past(reg_wdata[8:5]))
    else $error("technology field write lost");

  fault_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && hit ##1 restart_rise |-> ##2 adv_remote_fault == $past(link.staged[13]))
    else $error("remote fault not advertised");

  active_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !load_q |=> $stable(adv_word) && $stable(adv_tech_ability))
    else $error("active advertisement changed without restart");

  restart_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    restart_rise |-> ##2 adv_word == $past(link.staged) && adv_update)
    else $error("restart did not load advertisement");

  fdx_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    load_q && !link.staged[8] |=> !adv_fdx_100tx && !adv_tech_ability[3])
    else $error("100TX full duplex still advertised");

  read_back_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && hit |=> reg_rdata == $past(link.staged))
    else $error("read data mismatch");

  unmapped_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    !(reg_rd && hit) |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");

  pending_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && hit && (reg_wdata[8:5] != link.active[8:5]) && !restart_negotiation && !load_q
      ##1 !load_q |=> adv_pending)
    else $error("pending flag not raised after edit");

  // the split field flops and the word must never disagree, or the engine sees two advertisements
  field_mirror_a: assert property (@(posedge sys_clk) disable iff (rst)
    adv_tech_ability == adv_word[8:5] && adv_remote_fault == adv_word[13] && adv_fdx_100tx == adv_word[8])
    else $error("advertised fields differ from advertised word");

  staged_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !(reg_wr && hit) |=> $stable(link.staged))
    else $error("staged copy changed without a write to it");

  active_reserved_a: assert property (@(posedge sys_clk) disable iff (rst)
    adv_word[15] == 1'b0 && (adv_word & aar_pkg::ADV_RSVD_MASK) == 16'h0000)
    else $error("read-only bits set in active advertisement");

  pending_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    load_q |=> !adv_pending)
    else $error("pending flag still set after restart");

  update_source_a: assert property (@(posedge sys_clk) disable iff (rst)
    adv_update |-> $past(load_q))
    else $error("update pulse without a restart load");
endmodule // aar_top

/* File: bench/aar_partner.sv */
/*
  Far side stand-in: control logic raising restart and the engine that
  latches the advertisement. Assumes kick is a one-cycle bench request.
*/
`timescale 1ns/1ps
module aar_partner (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        kick,
  input  wire logic [15:0] adv_word,
  input  wire logic        adv_update,
  output logic             restart_negotiation,
  output logic      [15:0] seen
);
  // one-cycle restart keeps the low gap before the next request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) restart_negotiation <= 1'b0;
    else restart_negotiation <= kick;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) seen <= '0;
    else if (adv_update) seen <= adv_word;
  end
endmodule // aar_partner

/* File: bench/tb_top.sv */
/*
  Self-checking bench for the advertisement register.
  Assumes the partner model drives restart_negotiation.
*/
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  reg_addr = '0;
  logic [15:0] reg_wdata = '0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        kick = 1'b0;
  logic [15:0] reg_rdata, adv_word, seen, stg, act, d, w;
  logic [3:0]  adv_tech_ability;
  logic        restart_negotiation, adv_remote_fault, adv_fdx_100tx, adv_update, adv_pending;
  int          mismatches = 0;
  int          checks_done = 0;
  int          cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  aar_top dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .restart_negotiation(restart_negotiation),
    .adv_word(adv_word), .adv_remote_fault(adv_remote_fault), .adv_tech_ability(adv_tech_ability),
    .adv_fdx_100tx(adv_fdx_100tx), .adv_update(adv_update), .adv_pending(adv_pending));
  aar_partner peer (.sys_clk(sys_clk), .rst(rst), .kick(kick), .adv_word(adv_word),
    .adv_update(adv_update), .restart_negotiation(restart_negotiation), .seen(seen));
  function automatic logic [15:0] expect_w(input logic [15:0] v);
    return (v & 16'h21e0) | 16'h0001;
  endfunction
  task automatic conclude;
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data only stands in the cycle after the strobe
  task automatic rd(input logic [4:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic renegotiate(input logic with_wr, input logic [15:0] v);
    int n;
    @(posedge sys_clk);
    kick <= 1'b1;
    // a write beside the restart must still reach the advertisement
    if (with_wr) begin
      reg_addr <= 5'h04;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      stg = expect_w(v);
    end
    @(posedge sys_clk);
    kick <= 1'b0;
    reg_wr <= 1'b0;
    n = 0;
    while (adv_update !== 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 8) mismatches++;
    act = stg;
    chk(adv_word, act);
    chk({adv_remote_fault, adv_fdx_100tx, adv_tech_ability, 10'h000}, {act[13], act[8], act[8:5], 10'h000});
    @(negedge sys_clk);
    chk(seen, act);
    chk({15'h0000, adv_pending}, 16'h0000);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      conclude;
    end
  end
  initial begin
    w = 16'($urandom(81109));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk(adv_word, 16'h01e1);
    rd(5'h04);
    chk(d, 16'h01e1);
    stg = 16'h01e1;
    act = stg;
    for (int i = 0; i < 24; i++) begin
      w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
      wr(5'h04, w);
      stg = expect_w(w);
      rd(5'h04);
      chk(d, stg);
      chk(adv_word, act);
      chk({15'h0000, adv_pending}, {15'h0000, stg != act});
      if (i % 3 != 2) renegotiate(i % 3 == 1, 16'($urandom));
    end
    // unmapped place reads zero and leaves the register alone
    wr(5'h03, 16'h0000);
    rd(5'h03);
    chk(d, 16'h0000);
    rd(5'h04);
    chk(d, stg);
    // reset in mid-run must bring back the reset advertisement
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    stg = 16'h01e1;
    act = stg;
    chk(adv_word, act);
    chk({adv_remote_fault, adv_fdx_100tx, adv_tech_ability, 10'h000}, {act[13], act[8], act[8:5], 10'h000});
    chk({15'h0000, adv_pending}, 16'h0000);
    rd(5'h04);
    chk(d, stg);
    conclude;
  end
endmodule // tb_top
